/* File: hw/nsc_pkg.sv */
// nsc_pkg: constants and types shared by the nibble slice controller
// assumes: one 40 MHz clock, synchronous active-high reset
package nsc_pkg;
    // ----------
    // sizes
    // ----------
    localparam int unsigned UPPER_SLICES = 7;          // slices in the upper nibble
    localparam int unsigned LOWER_SLICES = 6;          // slices in the lower nibble
    localparam int unsigned REG_COUNT    = 64;         // register file depth
    localparam int unsigned REG_WIDTH    = 16;         // register data width
    localparam int unsigned ADDR_WIDTH   = 6;          // register index width
    localparam int unsigned BUS_AW       = 8;          // avalon byte address width
    // ----------
    // master clock setting, tenths of MHz
    // ----------
    localparam logic [15:0] FREQ_MIN     = 16'h07d0;   // 200.0
    localparam logic [15:0] FREQ_MAX     = 16'h5dc0;   // 2400.0
    localparam logic [15:0] FREQ_DEF     = 16'h0bb8;   // 300.0
    // ----------
    // register indices (byte address = 4 * index)
    // ----------
    localparam logic [5:0] IDX_CTRL      = 6'h00;      // gating and calibration control
    localparam logic [5:0] IDX_STATUS    = 6'h01;      // sticky event status
    localparam logic [5:0] IDX_IRQ_EN    = 6'h02;      // interrupt enable
    localparam logic [5:0] IDX_IRQ_CLR   = 6'h03;      // write-one clear
    localparam logic [5:0] IDX_FREQ      = 6'h04;      // master clock setting
    localparam logic [5:0] IDX_DELAY     = 6'h05;      // requested delay, ps
    localparam logic [5:0] IDX_CFG       = 6'h06;      // static config readback
    localparam logic [5:0] IDX_TAPS      = 6'h07;      // computed tap count
    localparam logic [5:0] IDX_AVAIL     = 6'h08;      // available slice mask
    // ----------
    // ctrl bits
    // ----------
    localparam int unsigned CTRL_RX_GATE = 0;          // receive gate enable
    localparam int unsigned CTRL_TX_GATE = 1;          // transmit gate enable
    localparam int unsigned CTRL_TIME    = 2;          // time delay format
    localparam int unsigned CTRL_RECAL   = 3;          // restart calibration
    localparam int unsigned CTRL_CLKDIV  = 4;          // slice clocks divide select
    // ----------
    // status bits
    // ----------
    localparam int unsigned ST_RDY       = 0;          // calibration done event
    localparam int unsigned ST_FREQ_ERR  = 1;          // frequency write out of range
    localparam int unsigned ST_BAD_ADDR  = 2;          // unmapped access
    localparam int unsigned ST_BITS      = 3;
    // ----------
    // calibration timing
    // ----------
    localparam int unsigned CAL_TIME_US  = 10;         // settle time per calibration
    localparam int unsigned CLK_MHZ      = 40;
    localparam int unsigned CAL_CYCLES   = CAL_TIME_US * CLK_MHZ;
    localparam int unsigned TAP_PS       = 5;          // nominal tap size, ps
    // ----------
    // types
    // ----------
    typedef enum logic [1:0] {
        NSC_IDLE = 2'b00,
        NSC_WAIT = 2'b01,
        NSC_CALC = 2'b11,
        NSC_DONE = 2'b10
    } nsc_cal_state_t;

    typedef struct packed {
        logic       clk_inv;       // clock invert select
        logic       rst_inv;       // reset invert select
        logic       dly_rst_inv;   // delay reset invert select
        logic       odly_bypass;   // output delay bypass
    } nsc_cfg_t;

    typedef struct packed {
        logic       rx_clk_en;     // receive clock enable pulse
        logic       tx_clk_en;     // transmit clock enable pulse
        logic       rx_gate;       // receive gating
        logic       tx_gate;       // transmit gating
    } nsc_slice_ctl_t;
endpackage : nsc_pkg

/* File: hw/nsc_slice.sv */
// nsc_slice: per-slice polarity, bypass and availability decode
// assumes: static settings from parameters, signals on the system clock
`timescale 1ns/1ps
`default_nettype none
module nsc_slice #(
    parameter nsc_pkg::nsc_cfg_t CFG = '0
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    rst_in,
    input  wire logic                    dly_rst_in,
    input  wire logic                    avail,
    input  wire nsc_pkg::nsc_slice_ctl_t ctl,
    output logic                         slice_clk_q,
    output logic                         slice_rst_q,
    output logic                         slice_dly_rst_q,
    output logic                         slice_bypass_q,
    output nsc_pkg::nsc_slice_ctl_t      slice_ctl_q
);
    // ----------
    // next values
    // ----------
    logic                    clk_d;
    logic                    rst_d;
    logic                    dly_d;
    nsc_pkg::nsc_slice_ctl_t ctl_d;

    // polarity and gating per slice; unavailable slices get no clock enable and no control, resets still pass
    always_comb begin
        clk_d = (ctl.rx_clk_en & avail) ^ CFG.clk_inv;
        rst_d = rst_in ^ CFG.rst_inv;
        dly_d = dly_rst_in ^ CFG.dly_rst_inv;
        ctl_d = avail ? ctl : '0;
    end

    // register everything so outputs come from flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slice_clk_q     <= 1'b0;
            slice_rst_q     <= 1'b1;
            slice_dly_rst_q <= 1'b1;
            slice_bypass_q  <= 1'b0;
            slice_ctl_q     <= '0;
        end else begin
            slice_clk_q     <= clk_d;
            slice_rst_q     <= rst_d;
            slice_dly_rst_q <= dly_d;
            slice_bypass_q  <= CFG.odly_bypass;
            slice_ctl_q     <= ctl_d;
        end
    end
endmodule : nsc_slice
`default_nettype wire

/* File: hw/nsc_top.sv */
// nsc_top: nibble controller for one nibble of pin slices
// assumes: avalon-mm master on clk; reset pins arrive asynchronously
// Contract
// - one controller drives every slice of nibble
// - calibrate delays, make slice clocks, keep registers
// - control receive and transmit gating per slice
// - sixty-four 16-bit registers behind the port
// - full control only through the register port
// - each nibble controller has its own port
// - merged ports look like one port
// - calibration converts delay using master frequency
// - time format calibration limits slice availability
// - clock invert select inverts slice clock
// - delay reset invert select inverts delay reset
// - reset invert select inverts main reset
// - output delay bypass routes around delay
// - delay ready flag output and register bit
// - six-bit address selects next cycle access
`timescale 1ns/1ps
`default_nettype none
module nsc_top #(
    parameter int unsigned       SLICES      = nsc_pkg::UPPER_SLICES,
    parameter bit                CLK_INV     = 1'b0,
    parameter bit                RST_INV     = 1'b0,
    parameter bit                DLY_RST_INV = 1'b0,
    parameter bit                ODLY_BYPASS = 1'b0,
    parameter logic [15:0]       FREQ_INIT   = nsc_pkg::FREQ_DEF
) (
    input  wire logic                              clk,
    input  wire logic                              sys_rst,
    // avalon-mm slave
    input  wire logic [nsc_pkg::BUS_AW-1:0]        avs_address,
    input  wire logic                              avs_read,
    input  wire logic                              avs_write,
    input  wire logic [31:0]                       avs_writedata,
    input  wire logic [3:0]                        avs_byteenable,
    output logic      [31:0]                       avs_readdata,
    output logic                                   avs_waitrequest,
    output logic      [1:0]                        avs_response,
    // pins from outside
    input  wire logic                              rst_pin,
    input  wire logic                              delay_reset,
    // outputs
    output logic                                   delay_ready_flag,
    output logic                                   irq,
    output logic      [SLICES-1:0]                 slice_clk,
    output logic      [SLICES-1:0]                 slice_rst,
    output logic      [SLICES-1:0]                 slice_dly_rst,
    output logic      [SLICES-1:0]                 slice_bypass,
    output nsc_pkg::nsc_slice_ctl_t [SLICES-1:0]   slice_ctl
);
    // ----------
    // static configuration
    // ----------
    localparam nsc_pkg::nsc_cfg_t CFG = '{clk_inv: CLK_INV, rst_inv: RST_INV,
        dly_rst_inv: DLY_RST_INV, odly_bypass: ODLY_BYPASS};

    // ----------
    // pin synchronisers
    // ----------
    logic [1:0] rst_meta_q;      // first stage
    logic [1:0] rst_sync_q;      // second stage: bit0 rst, bit1 delay reset

    // two flops per pin before any use
    always_ff @(posedge clk) begin
        rst_meta_q <= {delay_reset, rst_pin};
        rst_sync_q <= rst_meta_q;
    end

    // ----------
    // register state
    // ----------
    logic [4:0]                   ctrl_q,   ctrl_d;     // control bits
    logic [nsc_pkg::ST_BITS-1:0]  stat_q,   stat_d;     // sticky status
    logic [nsc_pkg::ST_BITS-1:0]  ien_q,    ien_d;      // interrupt enable
    logic [15:0]                  freq_q,   freq_d;     // master clock tenths MHz
    logic [15:0]                  delay_q,  delay_d;    // requested delay ps
    logic [15:0]                  gp_q [nsc_pkg::REG_COUNT];  // plain storage
    logic [31:0]                  rdata_q,  rdata_d;
    logic                         wait_q,   wait_d;     // answer pacing
    logic [1:0]                   resp_q,   resp_d;
    logic                         irq_q;
    // ----------
    // calibration state
    // ----------
    nsc_pkg::nsc_cal_state_t      cal_q,    cal_d;
    logic [15:0]                  cnt_q,    cnt_d;
    logic [15:0]                  taps_q,   taps_d;
    logic                         rdy_q,    rdy_d;
    logic [SLICES-1:0]            avail_q,  avail_d;
    logic                         div_q,    div_d;      // slice clock divider

    // ----------
    // bus decode
    // ----------
    logic [nsc_pkg::ADDR_WIDTH-1:0] idx;                // register index
    logic                           req;                // new request
    logic                           wr_lo;              // low half writable
    logic                           mapped;
    logic [nsc_pkg::ST_BITS-1:0]    set_ev;             // events this cycle
    logic [15:0]                    rd_val;

    // index from byte address; one word per register
    assign idx    = avs_address[nsc_pkg::BUS_AW-1:2];
    assign req    = (avs_read | avs_write) & wait_q;     // one answer per request
    // a write lands only at the edge where waitrequest is low
    assign wr_lo  = avs_write & ~wait_q & (&avs_byteenable[1:0]);
    assign mapped = 1'b1;                               // all 64 indices backed

    // read mux, registers are 16 bits, upper bits zero
    always_comb begin
        case (idx)
            nsc_pkg::IDX_CTRL:    rd_val = {11'h000, ctrl_q};
            nsc_pkg::IDX_STATUS:  rd_val = {13'h0000, stat_q};
            nsc_pkg::IDX_IRQ_EN:  rd_val = {13'h0000, ien_q};
            nsc_pkg::IDX_IRQ_CLR: rd_val = 16'h0000;
            nsc_pkg::IDX_FREQ:    rd_val = freq_q;
            nsc_pkg::IDX_DELAY:   rd_val = delay_q;
            nsc_pkg::IDX_CFG:     rd_val = {11'h000, rdy_q, CFG};
            nsc_pkg::IDX_TAPS:    rd_val = taps_q;
            nsc_pkg::IDX_AVAIL:   rd_val = 16'(avail_q);
            default:              rd_val = gp_q[idx];
        endcase
    end

    // register writes, events and bus answer
    always_comb begin
        ctrl_d  = ctrl_q;
        ien_d   = ien_q;
        freq_d  = freq_q;
        delay_d = delay_q;
        rdata_d = rdata_q;
        resp_d  = resp_q;
        set_ev  = '0;
        // one wait cycle then answer: waitrequest drops one cycle later
        wait_d  = ~((avs_read | avs_write) & wait_q);
        ctrl_d[nsc_pkg::CTRL_RECAL] = 1'b0;             // self-clearing
        if (req) begin
            resp_d  = mapped ? 2'b00 : 2'b11;
            rdata_d = {16'h0000, rd_val};
        end
        if (wr_lo) begin
            case (idx)
                nsc_pkg::IDX_CTRL:   ctrl_d  = avs_writedata[4:0];
                nsc_pkg::IDX_IRQ_EN: ien_d   = avs_writedata[nsc_pkg::ST_BITS-1:0];
                nsc_pkg::IDX_DELAY:  delay_d = avs_writedata[15:0];
                nsc_pkg::IDX_FREQ: begin
                    // out of range setting rejected, old value kept
                    if (avs_writedata[15:0] >= nsc_pkg::FREQ_MIN &&
                        avs_writedata[15:0] <= nsc_pkg::FREQ_MAX) begin
                        freq_d = avs_writedata[15:0];
                    end else begin
                        set_ev[nsc_pkg::ST_FREQ_ERR] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (req & ~mapped) begin
            set_ev[nsc_pkg::ST_BAD_ADDR] = 1'b1;
        end
        if (rdy_d & ~rdy_q) begin
            set_ev[nsc_pkg::ST_RDY] = 1'b1;
        end
        // set wins over clear
        stat_d = stat_q;
        if (wr_lo && idx == nsc_pkg::IDX_IRQ_CLR) begin
            stat_d = stat_q & ~avs_writedata[nsc_pkg::ST_BITS-1:0];
        end
        stat_d = stat_d | set_ev;
    end

    // register file and bus flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q  <= '0;
            stat_q  <= '0;
            ien_q   <= '0;
            freq_q  <= FREQ_INIT;
            delay_q <= '0;
            rdata_q <= '0;
            wait_q  <= 1'b1;
            resp_q  <= 2'b00;
            irq_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            stat_q  <= stat_d;
            ien_q   <= ien_d;
            freq_q  <= freq_d;
            delay_q <= delay_d;
            rdata_q <= rdata_d;
            wait_q  <= wait_d;
            resp_q  <= resp_d;
            irq_q   <= |(stat_d & ien_d);
        end
    end

    // plain storage for indices without a dedicated function
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < nsc_pkg::REG_COUNT; i++) begin
                gp_q[i] <= '0;
            end
        end else if (wr_lo) begin
            gp_q[idx] <= avs_writedata[15:0];
        end
    end

    // ----------
    // self calibration
    // ----------
    logic [31:0] prod;     // delay * freq, tenths MHz * ps
    logic [31:0] tap_calc;
    logic        in_rst;

    assign in_rst   = rst_sync_q[0] ^ CFG.rst_inv;
    // taps scale with delay and master frequency: larger setting means
    // a shorter master period so more taps for the same fraction
    assign prod     = 32'(delay_q) * 32'(freq_q);
    assign tap_calc = prod / 32'(nsc_pkg::TAP_PS * nsc_pkg::FREQ_DEF / 16'd10 * 32'd10);

    // calibration sequence: wait settle, compute taps, done
    always_comb begin
        cal_d   = cal_q;
        cnt_d   = cnt_q;
        taps_d  = taps_q;
        rdy_d   = rdy_q;
        avail_d = avail_q;
        case (cal_q)
            nsc_pkg::NSC_IDLE: begin
                cnt_d = '0;
                rdy_d = 1'b0;
                cal_d = nsc_pkg::NSC_WAIT;
            end
            nsc_pkg::NSC_WAIT: begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(nsc_pkg::CAL_CYCLES - 1)) begin
                    cal_d = nsc_pkg::NSC_CALC;
                end
            end
            nsc_pkg::NSC_CALC: begin
                taps_d = tap_calc[15:0];
                // time format reserves the last slice for calibration
                avail_d = ctrl_q[nsc_pkg::CTRL_TIME] ?
                          {1'b0, {(SLICES-1){1'b1}}} : {SLICES{1'b1}};
                cal_d  = nsc_pkg::NSC_DONE;
            end
            nsc_pkg::NSC_DONE: begin
                rdy_d = 1'b1;
            end
            default: cal_d = nsc_pkg::NSC_IDLE;
        endcase
        if (in_rst || ctrl_q[nsc_pkg::CTRL_RECAL]) begin
            cal_d = nsc_pkg::NSC_IDLE;
            rdy_d = 1'b0;
        end
    end

    // calibration flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cal_q   <= nsc_pkg::NSC_IDLE;
            cnt_q   <= '0;
            taps_q  <= '0;
            rdy_q   <= 1'b0;
            avail_q <= '0;
        end else begin
            cal_q   <= cal_d;
            cnt_q   <= cnt_d;
            taps_q  <= taps_d;
            rdy_q   <= rdy_d;
            avail_q <= avail_d;
        end
    end

    // ----------
    // slice clock enables
    // ----------
    nsc_pkg::nsc_slice_ctl_t ctl;

    // divider: every cycle or every other cycle
    always_comb begin
        div_d = ctrl_q[nsc_pkg::CTRL_CLKDIV] ? ~div_q : 1'b1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_q <= 1'b0;
        end else begin
            div_q <= div_d;
        end
    end

    // clocks only run after calibration
    always_comb begin
        ctl.rx_clk_en = div_q & rdy_q;
        ctl.tx_clk_en = div_q & rdy_q;
        ctl.rx_gate   = ctrl_q[nsc_pkg::CTRL_RX_GATE];
        ctl.tx_gate   = ctrl_q[nsc_pkg::CTRL_TX_GATE];
    end

    // one slice instance per pin, all driven by this controller
    for (genvar s = 0; s < SLICES; s++) begin : g_slice
        nsc_slice #(.CFG(CFG)) u_slice (
            .clk             (clk),
            .sys_rst         (sys_rst),
            .rst_in          (rst_sync_q[0]),
            .dly_rst_in      (rst_sync_q[1]),
            .avail           (avail_q[s]),
            .ctl             (ctl),
            .slice_clk_q     (slice_clk[s]),
            .slice_rst_q     (slice_rst[s]),
            .slice_dly_rst_q (slice_dly_rst[s]),
            .slice_bypass_q  (slice_bypass[s]),
            .slice_ctl_q     (slice_ctl[s])
        );
    end

    // ----------
    // outputs
    // ----------
    assign delay_ready_flag = rdy_q;
    assign irq              = irq_q;
    assign avs_readdata     = rdata_q;
    assign avs_waitrequest  = wait_q;
    assign avs_response     = resp_q;
endmodule : nsc_top
`default_nettype wire

/* File: tb/nsc_top_props.sv */
// nsc_top_props: port assertions for the nibble controller
// assumes: bound into nsc_top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module nsc_top_props #(
    parameter int unsigned SLICES      = 7,
    parameter bit          ODLY_BYPASS = 1'b0
) (
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic [1:0]        avs_response,
    input wire logic              rst_pin,
    input wire logic              delay_reset,
    input wire logic              delay_ready_flag,
    input wire logic              irq,
    input wire logic [SLICES-1:0] slice_rst,
    input wire logic [SLICES-1:0] slice_dly_rst,
    input wire logic [SLICES-1:0] slice_bypass
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----------
    // handshake: answer exactly one edge after the request is taken
    // ----------
    a_take_one_edge: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered next edge");
    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_no_idle_ack: assert property (!(avs_read || avs_write) && avs_waitrequest
        |=> avs_waitrequest) else $error("answer without request");
    a_resp_okay: assert property (avs_response == 2'b00) else $error("bad response");
    a_data_16bit: assert property (avs_readdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    // ----------
    // pins and static settings reach the slices
    // ----------
    a_dly_rst_follow: assert property (delay_reset [*5] |-> slice_dly_rst[0])
        else $error("delay reset not passed on");
    a_rst_follow: assert property (rst_pin [*5] |-> slice_rst[0])
        else $error("reset pin not passed on");
    a_ready_drop: assert property (rst_pin [*5] |-> !delay_ready_flag)
        else $error("ready held through reset pin");
    a_bypass_fixed: assert property (slice_bypass == {SLICES{ODLY_BYPASS}})
        else $error("bypass differs from setting");
    // main scenarios reached
    c_write: cover property (avs_write && !avs_waitrequest);
    c_read: cover property (avs_read && !avs_waitrequest);
    c_irq: cover property ($rose(irq));
    c_ready: cover property ($rose(delay_ready_flag));
endmodule : nsc_top_props
bind nsc_top nsc_top_props #(.SLICES(SLICES), .ODLY_BYPASS(ODLY_BYPASS)) props_i (.clk,
    .sys_rst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response,
    .rst_pin, .delay_reset, .delay_ready_flag, .irq, .slice_rst, .slice_dly_rst,
    .slice_bypass);
`default_nettype wire

/* File: tb/nsc_bus_master.sv */
// nsc_bus_master: avalon-mm master standing in for the interconnect
// assumes: xfer is entered just after a rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module nsc_bus_master (
    input  wire logic        clk,
    output logic [7:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // idle bus: no strobe, address parked at zero
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
    end
    // one access, held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [5:0] i, input logic [15:0] d,
                        input logic [3:0] b, output logic [15:0] q);
        avs_address <= {i, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= b;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= 8'h00;
        avs_writedata <= ~avs_writedata; // released data must not look valid
        @(posedge clk);
    endtask : xfer
endmodule : nsc_bus_master
`default_nettype wire

/* File: tb/test_nsc_top.sv */
// test_nsc_top: self-checking bench for the nibble controller
// assumes: nsc_pkg and the bus master model compiled first
`timescale 1ns/1ps
`default_nettype none
module test_nsc_top;
    logic        clk, sys_rst, rst_pin, delay_reset, delay_ready_flag, irq;
    logic [7:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [1:0]  avs_response;
    logic [6:0]  slice_clk, slice_rst, slice_dly_rst, slice_bypass;
    nsc_pkg::nsc_slice_ctl_t [6:0] slice_ctl;
    logic [15:0] v;
    logic [15:0] fv[4] = '{16'h07d0, 16'h07cf, 16'h5dc1, 16'h5dc0};
    logic [15:0] fe[4] = '{16'h07d0, 16'h07d0, 16'h07d0, 16'h5dc0};
    int          error_cnt, comparisons;
    nsc_top nsc_top_i (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .rst_pin,
        .delay_reset, .delay_ready_flag, .irq, .slice_clk, .slice_rst, .slice_dly_rst,
        .slice_bypass, .slice_ctl);
    nsc_bus_master nsc_bus_master_i (.clk, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // compare one value and count it
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic [3:0] b = 4'hf);
        nsc_bus_master_i.xfer(1'b1, i, d, b, v);
    endtask : wr
    task automatic rd(input logic [5:0] i);
        nsc_bus_master_i.xfer(1'b0, i, 16'h0000, 4'hf, v);
    endtask : rd
    // bounded wait for calibration to finish
    task automatic wait_rdy();
        for (int k = 0; k < 600 && delay_ready_flag !== 1'b1; k++) @(posedge clk);
        chk("ready_pin", 16'h0001, {15'h0, delay_ready_flag});
    endtask : wait_rdy
    task automatic t_boot();
        chk("ready_early", 16'h0000, {15'h0, delay_ready_flag});
        rd(nsc_pkg::IDX_FREQ);
        chk("freq_default", 16'h0bb8, v);
        rd(nsc_pkg::IDX_CFG);
        chk("cfg_static", 16'h0000, v & 16'h000f);
        wait_rdy();
        rd(nsc_pkg::IDX_CFG);
        chk("cfg_ready", 16'h0010, v & 16'h0010);
        chk("slice_clk", 16'h007f, {9'h0, slice_clk});
        $display("boot done");
    endtask : t_boot
    task automatic t_freq();
        for (int k = 0; k < 4; k++) begin
            wr(nsc_pkg::IDX_FREQ, fv[k]);
            rd(nsc_pkg::IDX_FREQ);
            chk("freq", fe[k], v);
        end
        wr(nsc_pkg::IDX_FREQ, 16'h07d0, 4'h1);
        rd(nsc_pkg::IDX_FREQ);
        chk("freq_partial", 16'h5dc0, v);
        $display("freq done");
    endtask : t_freq
    task automatic t_irq();
        wr(nsc_pkg::IDX_IRQ_CLR, 16'h0007);
        wr(nsc_pkg::IDX_IRQ_EN, 16'h0000);
        wr(nsc_pkg::IDX_FREQ, 16'h0000);
        rd(nsc_pkg::IDX_STATUS);
        chk("st_freq_err", 16'h0002, v & 16'h0002);
        chk("irq_masked", 16'h0000, {15'h0, irq});
        wr(nsc_pkg::IDX_IRQ_EN, 16'h0002);
        rd(nsc_pkg::IDX_IRQ_EN);
        chk("irq_on", 16'h0001, {15'h0, irq});
        wr(nsc_pkg::IDX_IRQ_CLR, 16'h0002);
        rd(nsc_pkg::IDX_IRQ_CLR);
        chk("clr_reads0", 16'h0000, v);
        chk("irq_off", 16'h0000, {15'h0, irq});
        $display("irq done");
    endtask : t_irq
    task automatic t_regs();
        for (int i = 9; i < 64; i++) wr(6'(i), 16'(i * 16'h0405) ^ 16'hc3c3);
        for (int i = 9; i < 64; i++) begin
            rd(6'(i));
            chk("reg_file", 16'(i * 16'h0405) ^ 16'hc3c3, v);
        end
        $display("regs done");
    endtask : t_regs
    task automatic t_gate();
        wr(nsc_pkg::IDX_CTRL, 16'h0013);
        repeat (4) @(posedge clk);
        chk("gates", 16'h0003, {14'h0, slice_ctl[6].rx_gate, slice_ctl[0].tx_gate});
        v[0] = slice_clk[0];
        @(posedge clk);
        chk("clk_div", 16'h0001, {15'h0, v[0] ^ slice_clk[0]});
        wr(nsc_pkg::IDX_CTRL, 16'h000c);
        repeat (8) @(posedge clk);
        wait_rdy();
        rd(nsc_pkg::IDX_AVAIL);
        chk("avail_time", 16'h003f, v);
        $display("gate done");
    endtask : t_gate
    task automatic t_pins();
        delay_reset <= 1'b1;
        repeat (6) @(posedge clk);
        chk("dly_rst_on", 16'h007f, {9'h0, slice_dly_rst});
        delay_reset <= 1'b0;
        rst_pin <= 1'b1;
        repeat (6) @(posedge clk);
        chk("dly_rst_off", 16'h0000, {9'h0, slice_dly_rst});
        chk("rst_on", 16'h007f, {9'h0, slice_rst});
        rst_pin <= 1'b0;
        wait_rdy();
        chk("rst_off", 16'h0000, {9'h0, slice_rst});
        $display("pins done");
    endtask : t_pins
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // watchdog: all tests need well under this many cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        sys_rst = 1'b1;
        rst_pin = 1'b0;
        delay_reset = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_boot();
        t_freq();
        t_irq();
        t_regs();
        t_gate();
        t_pins();
        tally_and_finish();
    end
endmodule : test_nsc_top
`default_nettype wire
